// ### hdl/lopc_regs.sv
// led override register and phy misc control register with their outputs
// assumes register strobes and status inputs come from ref_clk logic;
// only the crossover strap is asynchronous and is synchronised here
//
// What this block does
// - led override bits 15:6 ignore writes, read zero
// - speed override enable drives speed led value
// - link override enable drives link led value
// - activity override enable drives activity led value
// - led override reads stored settings, never pins
// - bit 15 auto crossover enable, strap reset value
// - auto crossover needs auto-negotiation enabled
// - force crossover swaps transmit and receive pairs
// - pause receive resolved, full duplex only
// - pause transmit resolved, full duplex only
// - inject error writes one pulse, self clears
// - selftest run, sequence select, latched pass flag
// - stretch bypass shows raw activity event
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module lopc_regs #(
	parameter int STRETCH_CYCLES = lopc_pkg::STRETCH_CYCLES_DEF
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic mdix_strap_pin,
	input wire logic an_enable,
	input wire logic hcd_full_duplex,
	input wire logic [1:0] local_pause_adv,
	input wire logic [1:0] partner_pause_adv,
	input wire logic speed_event,
	input wire logic link_event,
	input wire logic activity_event,
	input wire logic selftest_error,
	output logic speed_indicator_out,
	output logic link_indicator_out,
	output logic activity_collision_indicator_out,
	output logic auto_crossover_active,
	output logic force_pair_crossover,
	output logic selftest_run,
	output logic selftest_long_sequence_sel,
	output logic selftest_inject_error,
	output logic indicator_stretch_bypass
);
	localparam int CNT_W = $clog2(STRETCH_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(STRETCH_CYCLES);

	logic [5:0] led_ovr_reg;
	logic auto_crossover_enable_reg;
	logic pause_rx_reg;
	logic pause_tx_reg;
	logic selftest_pass_flag_reg;
	logic run_d_reg;
	logic strap_meta_reg;
	logic strap_sync_reg;
	logic strap_loaded_reg;
	logic [CNT_W-1:0] stretch_cnt_reg;
	logic wr_led;
	logic wr_phy;
	logic rd_led;
	logic rd_phy;
	logic pause_rx_next;
	logic pause_tx_next;
	logic act_stretched;
	logic act_normal;

	assign wr_led = reg_wr && (reg_addr == lopc_pkg::LED_OVR_OFF);
	assign wr_phy = reg_wr && (reg_addr == lopc_pkg::PHY_MISC_OFF);
	assign rd_led = reg_rd && (reg_addr == lopc_pkg::LED_OVR_OFF);
	assign rd_phy = reg_rd && (reg_addr == lopc_pkg::PHY_MISC_OFF);

	// only the low six bits have storage, so upper writes vanish
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			led_ovr_reg <= lopc_pkg::LED_OVR_RESET;
		end else if (wr_led) begin
			led_ovr_reg <= reg_wdata[lopc_pkg::LED_FIELD_W-1:0];
		end
	end

	// strap synchroniser; not reset so it tracks the pin during reset
	always_ff @(posedge ref_clk) begin
		strap_meta_reg <= mdix_strap_pin;
		strap_sync_reg <= strap_meta_reg;
	end

	// strap is taken in the first cycle after reset release
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			strap_loaded_reg <= 1'b0;
			auto_crossover_enable_reg <= 1'b0;
		end else if (!strap_loaded_reg) begin
			strap_loaded_reg <= 1'b1;
			auto_crossover_enable_reg <= strap_sync_reg;
		end else if (wr_phy) begin
			auto_crossover_enable_reg <= reg_wdata[lopc_pkg::PHY_AUTO_CROSSOVER_ENABLE_BIT];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			auto_crossover_active <= 1'b0;
		end else begin
			auto_crossover_active <= auto_crossover_enable_reg && an_enable;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			force_pair_crossover <= 1'b0;
			selftest_long_sequence_sel <= 1'b0;
			selftest_run <= 1'b0;
			indicator_stretch_bypass <= 1'b0;
		end else if (wr_phy) begin
			force_pair_crossover <= reg_wdata[lopc_pkg::PHY_FORCE_X_BIT];
			selftest_long_sequence_sel <= reg_wdata[lopc_pkg::PHY_LONG_SEQ_BIT];
			selftest_run <= reg_wdata[lopc_pkg::PHY_RUN_BIT];
			indicator_stretch_bypass <= reg_wdata[lopc_pkg::PHY_BYPASS_BIT];
		end
	end

	// one-cycle pulse; the stored bit never reads back as one
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			selftest_inject_error <= 1'b0;
		end else begin
			selftest_inject_error <= wr_phy && reg_wdata[lopc_pkg::PHY_INJECT_BIT];
		end
	end

	// pass flag: set on start, an error latches it low until the next start
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			run_d_reg <= 1'b0;
			selftest_pass_flag_reg <= 1'b0;
		end else begin
			run_d_reg <= selftest_run;
			if (!selftest_run) begin
				selftest_pass_flag_reg <= 1'b0;
			end else if (selftest_error) begin
				selftest_pass_flag_reg <= 1'b0;
			end else if (!run_d_reg) begin
				selftest_pass_flag_reg <= 1'b1;
			end
		end
	end

	// symmetric and asymmetric pause resolution
	always_comb begin
		pause_rx_next = 1'b0;
		pause_tx_next = 1'b0;
		if (hcd_full_duplex) begin
			if (local_pause_adv[lopc_pkg::ADV_PAUSE] && partner_pause_adv[lopc_pkg::ADV_PAUSE]) begin
				pause_rx_next = 1'b1;
				pause_tx_next = 1'b1;
			end else if (local_pause_adv == 2'h3 && partner_pause_adv == 2'h2) begin
				pause_rx_next = 1'b1;
			end else if (local_pause_adv == 2'h2 && partner_pause_adv == 2'h3) begin
				pause_tx_next = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pause_rx_reg <= 1'b0;
			pause_tx_reg <= 1'b0;
		end else begin
			pause_rx_reg <= pause_rx_next;
			pause_tx_reg <= pause_tx_next;
		end
	end

	// activity stretch; an event restarts the hold, so bursts merge
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			stretch_cnt_reg <= '0;
		end else if (activity_event) begin
			stretch_cnt_reg <= CNT_LOAD;
		end else if (stretch_cnt_reg != '0) begin
			stretch_cnt_reg <= stretch_cnt_reg - CNT_W'(1);
		end
	end

	assign act_stretched = activity_event || (stretch_cnt_reg != '0);
	assign act_normal = indicator_stretch_bypass ? activity_event : act_stretched;

	// indicator outputs are registered, one cycle behind the register
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			speed_indicator_out <= 1'b0;
			link_indicator_out <= 1'b0;
			activity_collision_indicator_out <= 1'b0;
		end else begin
			speed_indicator_out <= led_ovr_reg[lopc_pkg::SPEED_INDICATOR_OUT_EN_BIT] ?
				led_ovr_reg[lopc_pkg::SPEED_INDICATOR_OUT_VAL_BIT] : speed_event;
			link_indicator_out <= led_ovr_reg[lopc_pkg::LINK_INDICATOR_OUT_EN_BIT] ?
				led_ovr_reg[lopc_pkg::LINK_INDICATOR_OUT_VAL_BIT] : link_event;
			activity_collision_indicator_out <= led_ovr_reg[lopc_pkg::LED_ACT_EN_BIT] ?
				led_ovr_reg[lopc_pkg::LED_ACT_VAL_BIT] : act_normal;
		end
	end

	// read data exist only in the cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			reg_rdata <= 16'h0000;
		end else if (rd_led) begin
			reg_rdata <= {10'h000, led_ovr_reg};
		end else if (rd_phy) begin
			reg_rdata <= {auto_crossover_enable_reg, force_pair_crossover,
				pause_rx_reg, pause_tx_reg, 1'b0, selftest_long_sequence_sel,
				selftest_pass_flag_reg, selftest_run, indicator_stretch_bypass, 7'h00};
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	sequence s_led_rd;
		reg_rd && (reg_addr == lopc_pkg::LED_OVR_OFF);
	endsequence

	sequence s_spd_force_wr;
		reg_wr && (reg_addr == lopc_pkg::LED_OVR_OFF) && reg_wdata[5] && reg_wdata[2];
	endsequence

	sequence s_inject_wr;
		reg_wr && (reg_addr == lopc_pkg::PHY_MISC_OFF) && reg_wdata[11];
	endsequence

	sequence s_run_err;
		selftest_run && selftest_error;
	endsequence

	property p_led_rsvd;
		@(posedge ref_clk) disable iff (!rst_b)
		s_led_rd |=> (reg_rdata[15:6] == 10'h000);
	endproperty
	a_led_rsvd: assert property (p_led_rsvd) else $error("led reserved bits not zero");

	property p_spd_ovr;
		@(posedge ref_clk) disable iff (!rst_b)
		led_ovr_reg[5] |=> (speed_indicator_out == $past(led_ovr_reg[2]));
	endproperty
	a_spd_ovr: assert property (p_spd_ovr) else $error("speed override not driven");

	property p_spd_norm;
		@(posedge ref_clk) disable iff (!rst_b)
		!led_ovr_reg[5] |=> (speed_indicator_out == $past(speed_event));
	endproperty
	a_spd_norm: assert property (p_spd_norm) else $error("speed normal path wrong");

	property p_lnk_ovr;
		@(posedge ref_clk) disable iff (!rst_b)
		led_ovr_reg[4] |=> (link_indicator_out == $past(led_ovr_reg[1]));
	endproperty
	a_lnk_ovr: assert property (p_lnk_ovr) else $error("link override not driven");

	property p_act_ovr;
		@(posedge ref_clk) disable iff (!rst_b)
		led_ovr_reg[3] |=> (activity_collision_indicator_out == $past(led_ovr_reg[0]));
	endproperty
	a_act_ovr: assert property (p_act_ovr) else $error("activity override not driven");

	property p_led_readback;
		@(posedge ref_clk) disable iff (!rst_b)
		s_led_rd |=> (reg_rdata[5:0] == $past(led_ovr_reg));
	endproperty
	a_led_readback: assert property (p_led_readback) else $error("led readback wrong");

	property p_xover_gate;
		@(posedge ref_clk) disable iff (!rst_b)
		!an_enable |=> !auto_crossover_active;
	endproperty
	a_xover_gate: assert property (p_xover_gate) else $error("crossover active without an");

	property p_pause_sym;
		@(posedge ref_clk) disable iff (!rst_b)
		(hcd_full_duplex && local_pause_adv[0] && partner_pause_adv[0]) |=>
			(pause_rx_reg && pause_tx_reg);
	endproperty
	a_pause_sym: assert property (p_pause_sym) else $error("symmetric pause missed");

	property p_pause_hd;
		@(posedge ref_clk) disable iff (!rst_b)
		!hcd_full_duplex |=> (!pause_rx_reg && !pause_tx_reg);
	endproperty
	a_pause_hd: assert property (p_pause_hd) else $error("pause set in half duplex");

	property p_inject;
		@(posedge ref_clk) disable iff (!rst_b)
		s_inject_wr ##1 !(wr_phy && reg_wdata[lopc_pkg::PHY_INJECT_BIT]) |->
			selftest_inject_error ##1 !selftest_inject_error;
	endproperty
	a_inject: assert property (p_inject) else $error("inject pulse not single");

	property p_pass_latch;
		@(posedge ref_clk) disable iff (!rst_b)
		s_run_err |=> !selftest_pass_flag_reg;
	endproperty
	a_pass_latch: assert property (p_pass_latch) else $error("fail not latched");

	property p_bypass;
		@(posedge ref_clk) disable iff (!rst_b)
		(indicator_stretch_bypass && !led_ovr_reg[3]) |=>
			(activity_collision_indicator_out == $past(activity_event));
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass not raw");

	property p_write_latency;
		@(posedge ref_clk) disable iff (!rst_b)
		s_spd_force_wr ##1 led_ovr_reg[5] |-> ##1 speed_indicator_out;
	endproperty
	a_write_latency: assert property (p_write_latency) else $error("override too slow");

	// once running past its first cycle, a low flag may only rise after a stop
	property p_pass_hold;
		@(posedge ref_clk) disable iff (!rst_b)
		(selftest_run && run_d_reg && !selftest_pass_flag_reg) |=> !selftest_pass_flag_reg;
	endproperty
	a_pass_hold: assert property (p_pass_hold) else $error("fail flag released while running");

	property p_lnk_norm;
		@(posedge ref_clk) disable iff (!rst_b)
		!led_ovr_reg[lopc_pkg::LINK_INDICATOR_OUT_EN_BIT] |=> (link_indicator_out == $past(link_event));
	endproperty
	a_lnk_norm: assert property (p_lnk_norm) else $error("link normal path wrong");

	property p_xover_on;
		@(posedge ref_clk) disable iff (!rst_b)
		(auto_crossover_enable_reg && an_enable) |=> auto_crossover_active;
	endproperty
	a_xover_on: assert property (p_xover_on) else $error("crossover not active");

	property p_force_follow;
		@(posedge ref_clk) disable iff (!rst_b)
		wr_phy |=> (force_pair_crossover == $past(reg_wdata[lopc_pkg::PHY_FORCE_X_BIT]));
	endproperty
	a_force_follow: assert property (p_force_follow) else $error("force crossover not taken");

	// read data must not linger, or a later poll could pick up a stale word
	property p_rdata_idle;
		@(posedge ref_clk) disable iff (!rst_b)
		!reg_rd |=> (reg_rdata == 16'h0000);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

endmodule

// ### shared/lopc_pkg.sv
// constants for the led override and phy misc control register pair
// assumes a 5-bit management address and 16-bit register data
package lopc_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam logic [4:0] LED_OVR_OFF = 5'h18;
	localparam logic [4:0] PHY_MISC_OFF = 5'h19;
	// led_direct_override fields
	localparam int SPEED_INDICATOR_OUT_EN_BIT = 5;
	localparam int LINK_INDICATOR_OUT_EN_BIT = 4;
	localparam int LED_ACT_EN_BIT = 3;
	localparam int SPEED_INDICATOR_OUT_VAL_BIT = 2;
	localparam int LINK_INDICATOR_OUT_VAL_BIT = 1;
	localparam int LED_ACT_VAL_BIT = 0;
	localparam int LED_FIELD_W = 6;
	localparam logic [5:0] LED_OVR_RESET = 6'h00;
	// phy_misc_control fields
	localparam int PHY_AUTO_CROSSOVER_ENABLE_BIT = 15;
	localparam int PHY_FORCE_X_BIT = 14;
	localparam int PHY_PAUSE_RX_BIT = 13;
	localparam int PHY_PAUSE_TX_BIT = 12;
	localparam int PHY_INJECT_BIT = 11;
	localparam int PHY_LONG_SEQ_BIT = 10;
	localparam int PHY_PASS_BIT = 9;
	localparam int PHY_RUN_BIT = 8;
	localparam int PHY_BYPASS_BIT = 7;
	// pause advertisement bit positions within the 2-bit field
	localparam int ADV_PAUSE = 0;
	localparam int ADV_ASYM = 1;
	// activity stretch length in clock cycles
	localparam int STRETCH_CYCLES_DEF = 1024;
endpackage

// ### tb/lopc_mgmt_model.sv
// management-side model: register bus master for the led and phy control pair
// assumes the block samples strobes on rising ref_clk and answers reads next cycle
`timescale 1ns/1ps
module lopc_mgmt_model (
	input wire logic ref_clk,
	output logic [4:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [15:0] reg_rdata
);
	initial begin
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// idle bus carries inverted leftovers so stale values never look valid
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask
endmodule

// ### tb/test_led_override_phy_control_regs.sv
// self-checking bench for the led override and phy misc control registers
// assumes lopc_mgmt_model as bus master; status inputs driven here
`timescale 1ns/1ps
module test_led_override_phy_control_regs;
	localparam int STRETCH = 4;
	localparam logic [4:0] L = lopc_pkg::LED_OVR_OFF;
	localparam logic [4:0] P = lopc_pkg::PHY_MISC_OFF;
	logic ref_clk, rst_b, strap, an_en, fd, sp_ev, lk_ev, act_ev, st_err;
	logic [1:0] lp, pp;
	logic [4:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d;
	logic reg_wr, reg_rd, spd_o, lnk_o, act_o, xo_o, frc_o, run_o, long_o, inj_o, byp_o;
	logic [4:0] v;
	int fail_count = 0, cmp_count = 0, ni, na;
	lopc_regs #(.STRETCH_CYCLES(STRETCH)) lopc_regs_inst (.ref_clk(ref_clk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .mdix_strap_pin(strap), .an_enable(an_en),
		.hcd_full_duplex(fd), .local_pause_adv(lp), .partner_pause_adv(pp),
		.speed_event(sp_ev), .link_event(lk_ev), .activity_event(act_ev),
		.selftest_error(st_err), .speed_indicator_out(spd_o), .link_indicator_out(lnk_o),
		.activity_collision_indicator_out(act_o), .auto_crossover_active(xo_o),
		.force_pair_crossover(frc_o), .selftest_run(run_o),
		.selftest_long_sequence_sel(long_o), .selftest_inject_error(inj_o),
		.indicator_stretch_bypass(byp_o));
	lopc_mgmt_model lopc_mgmt_model_inst (.ref_clk(ref_clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic w(input logic [4:0] a, input logic [15:0] x);
		lopc_mgmt_model_inst.wr(a, x);
	endtask
	task automatic r(input logic [4:0] a);
		lopc_mgmt_model_inst.rd(a, d);
	endtask
	task automatic settle();
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
	// counts high cycles of inject pulse and activity output over a short span
	task automatic cnt();
		ni = 0;
		na = 0;
		repeat (8) begin
			#1;
			ni += int'(inj_o === 1'b1);
			na += int'(act_o === 1'b1);
			@(posedge ref_clk);
		end
	endtask
	task automatic pulse_act();
		@(posedge ref_clk);
		act_ev <= 1'b1;
		@(posedge ref_clk);
		act_ev <= 1'b0;
		cnt();
	endtask
	function automatic logic [1:0] pause_exp(input logic [4:0] x);
		logic both;
		both = x[2] & x[0];
		pause_exp = {x[4] & (both | (x[3:2] == 2'b11 && x[1:0] == 2'b10)),
			x[4] & (both | (x[3:2] == 2'b10 && x[1:0] == 2'b11))};
	endfunction
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge ref_clk);
		fail_count++;
		final_report();
	end
	initial begin
		rst_b = 1'b0;
		strap = 1'b1;
		an_en = 1'b1;
		fd = 1'b0;
		lp = 2'b00;
		pp = 2'b00;
		{sp_ev, lk_ev, act_ev, st_err} = 4'h0;
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge ref_clk);
		r(L); check("led reset", d, 16'h0000);
		r(P); check("phy reset", d, 16'h8000);
		w(5'h1a, 16'hffff);
		r(5'h1a); check("unmapped", d, 16'h0000);
		w(L, 16'hffff); settle();
		r(L); check("led reserved", d, 16'h003f);
		check("leds forced on", 16'({spd_o, lnk_o, act_o}), 16'h0007);
		@(posedge ref_clk);
		{sp_ev, lk_ev, act_ev} <= 3'b111;
		w(L, 16'h0038); settle();
		check("leds forced off", 16'({spd_o, lnk_o, act_o}), 16'h0000);
		w(L, 16'h0007); settle();
		check("leds normal on", 16'({spd_o, lnk_o, act_o}), 16'h0007);
		@(posedge ref_clk);
		{sp_ev, lk_ev, act_ev} <= 3'b000;
		repeat (10) @(posedge ref_clk);
		#1;
		check("leds normal off", 16'({spd_o, lnk_o, act_o}), 16'h0000);
		r(L); check("led settings not pins", d, 16'h0007);
		w(P, 16'hc580); settle();
		check("phy outputs", 16'({xo_o, frc_o, long_o, run_o, byp_o}), 16'h001f);
		r(P); check("phy readback", d, 16'hc780);
		@(posedge ref_clk);
		an_en <= 1'b0;
		settle();
		check("crossover needs an", 16'(xo_o), 16'h0000);
		@(posedge ref_clk);
		st_err <= 1'b1;
		@(posedge ref_clk);
		st_err <= 1'b0;
		settle();
		r(P); check("pass latched low", 16'(d[9]), 16'h0000);
		w(P, 16'h4480); settle();
		check("selftest stopped", 16'({xo_o, run_o}), 16'h0000);
		w(P, 16'h4d80);
		cnt(); check("inject once", 16'(ni), 16'h0001);
		r(P); check("inject self clears", d, 16'h4780);
		pulse_act(); check("raw activity", 16'(na), 16'h0001);
		w(P, 16'h4500);
		pulse_act(); check("stretched activity", 16'(na), 16'(STRETCH + 1));
		for (int i = 0; i < 32; i++) begin
			v = 5'(i);
			@(posedge ref_clk);
			fd <= v[4];
			lp <= v[3:2];
			pp <= v[1:0];
			settle();
			r(P); check("pause resolution", 16'(d[13:12]), 16'(pause_exp(v)));
		end
		// second reset with the strap low: bit 15 must come back as zero
		@(posedge ref_clk);
		strap <= 1'b0;
		rst_b <= 1'b0;
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		check("outputs after reset", 16'({spd_o, lnk_o, act_o, xo_o, frc_o, run_o, long_o, inj_o, byp_o}), 16'h0000);
		r(P); check("strap low reset", d, {2'b00, pause_exp(5'h1f), 12'h000});
		r(L); check("led after reset", d, 16'h0000);
		final_report();
	end
endmodule
